//--- tmv_pkg.sv
// constants, register map and types shared by the timer interrupt vector block
package tmv_pkg;

   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int DATA_W   = 32;
   localparam int REG_W    = 16;
   localparam int ADDR_W   = 8;
   localparam int IDX_W    = 6;
   localparam int SLOT_W   = 3;
   localparam int NUM_CH   = 7;
   localparam int NUM_SRC  = 8;
   localparam int NUM_SLOT = 8;
   localparam int SHR_W    = 7;
   localparam int VEC_W    = 4;
   localparam int ST_W     = 2;
   localparam int STRB_W   = 4;
   localparam int BYTE_SH  = 2;
   localparam int STEP_SH  = 1;
   localparam int BYTE_W   = 8;

   // ***************************************************************
   // register indices (byte address is four times the index)
   // ***************************************************************
   localparam logic [IDX_W-1:0] IDX_TIMER_CONTROL    = 6'h00;
   localparam logic [IDX_W-1:0] IDX_CHANNEL0_CONTROL = 6'h02;
   localparam logic [IDX_W-1:0] IDX_CHANNEL1_CONTROL = 6'h04;
   localparam logic [IDX_W-1:0] IDX_CHANNEL2_CONTROL = 6'h06;
   localparam logic [IDX_W-1:0] IDX_CHANNEL3_CONTROL = 6'h08;
   localparam logic [IDX_W-1:0] IDX_CHANNEL4_CONTROL = 6'h0a;
   localparam logic [IDX_W-1:0] IDX_CHANNEL5_CONTROL = 6'h0c;
   localparam logic [IDX_W-1:0] IDX_CHANNEL6_CONTROL = 6'h0e;
   localparam logic [IDX_W-1:0] IDX_COUNTER_VALUE    = 6'h10;
   localparam logic [IDX_W-1:0] IDX_CHANNEL0_VALUE   = 6'h12;
   localparam logic [IDX_W-1:0] IDX_CHANNEL1_VALUE   = 6'h14;
   localparam logic [IDX_W-1:0] IDX_CHANNEL2_VALUE   = 6'h16;
   localparam logic [IDX_W-1:0] IDX_CHANNEL3_VALUE   = 6'h18;
   localparam logic [IDX_W-1:0] IDX_CHANNEL4_VALUE   = 6'h1a;
   localparam logic [IDX_W-1:0] IDX_CHANNEL5_VALUE   = 6'h1c;
   localparam logic [IDX_W-1:0] IDX_CHANNEL6_VALUE   = 6'h1e;
   localparam logic [IDX_W-1:0] IDX_CLOCK_EXPANSION  = 6'h20;
   localparam logic [IDX_W-1:0] IDX_IRQ_VECTOR       = 6'h2e;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS       = 6'h30;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK         = 6'h32;

   // ***************************************************************
   // fields and reset values
   // ***************************************************************
   localparam int FLAG_BIT   = 0;
   localparam int OVF_IE_BIT = 1;
   localparam int CH_IE_BIT  = 4;
   localparam logic [REG_W-1:0] REG_RESET   = 16'h0000;
   localparam logic [REG_W-1:0] FLAG_MASK   = 16'h0001;
   localparam logic [REG_W-1:0] TCTL_WMASK  = 16'h7bff;
   localparam int ST_SERVICED = 0;
   localparam int ST_UNMAPPED = 1;

   // ***************************************************************
   // vector codes and bus answers
   // ***************************************************************
   localparam logic [VEC_W-1:0] VEC_NONE = 4'h0;
   localparam logic [VEC_W-1:0] VEC_OVF  = 4'he;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} tmv_rd_state_t;
   typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} tmv_wr_state_t;

endpackage : tmv_pkg

//--- tmv_evflag.sv
// one interrupt flag cell: hardware event, software write and automatic clear
module tmv_evflag
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic ce_i,
   input  wire logic set_i,
   input  wire logic wr_i,
   input  wire logic wr_val_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   // an event in the same cycle as any clear keeps the flag set
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         flag_o <= 1'b0;
      else if (ce_i)
      begin
         if (set_i)
            flag_o <= 1'b1;
         else if (wr_i)
            flag_o <= wr_val_i;
         else if (clr_i)
            flag_o <= 1'b0;
      end
   end
endmodule : tmv_evflag

//--- tmv_prio.sv
// ranks the shared sources and yields the vector code and the one to clear
module tmv_prio
   import tmv_pkg::*;
(
   input  wire logic [SHR_W-1:0] pend_i,
   output logic      [VEC_W-1:0] code_o,
   output logic      [SHR_W-1:0] sel_o
);
   // walk from lowest rank upward so the highest rank wins
   always_comb
   begin
      code_o = VEC_NONE;
      sel_o  = '0;
      for (int i = SHR_W - 1; i >= 0; i--)
      begin
         if (pend_i[i])
         begin
            code_o = (i == SHR_W - 1) ? VEC_OVF : VEC_W'((i + 1) * 2);
            sel_o  = SHR_W'(1) << i;
         end
      end
   end
endmodule : tmv_prio

//--- tmv_top.sv
// timer register map with shared interrupt vector generator behind AXI4-Lite
// Notes on behaviour
// - overflow and channels 1-6 share one request
// - vector register names the requesting source
// - vector holds highest enabled pending source code
// - disabled sources never affect the vector
// - any vector access clears the reported flag
// - shared request stays high while enabled flags remain and global enable is high
// - channel 1 is cleared before channel 2
// - codes 0, 2..12 channels, 14 overflow
// - word registers reset zero, control first
// - channel controls, counter, values, expansion offsets
// - flags set by events or software writes
// - requests need channel and global enable
// - channel 0 own request, cleared on service
//
// The AXI4-Lite register port is this design's own decision.
module tmv_top
(
   input  wire logic                          CLOCK_I,
   input  wire logic                          RESETN_I,
   input  wire logic                          CE_I,
   input  wire logic [tmv_pkg::ADDR_W-1:0]    AWADDR_I,
   input  wire logic                          AWVALID_I,
   output logic                               AWREADY_O,
   input  wire logic [tmv_pkg::DATA_W-1:0]    WDATA_I,
   input  wire logic [tmv_pkg::STRB_W-1:0]    WSTRB_I,
   input  wire logic                          WVALID_I,
   output logic                               WREADY_O,
   output logic      [1:0]                    BRESP_O,
   output logic                               BVALID_O,
   input  wire logic                          BREADY_I,
   input  wire logic [tmv_pkg::ADDR_W-1:0]    ARADDR_I,
   input  wire logic                          ARVALID_I,
   output logic                               ARREADY_O,
   output logic      [tmv_pkg::DATA_W-1:0]    RDATA_O,
   output logic      [1:0]                    RRESP_O,
   output logic                               RVALID_O,
   input  wire logic                          RREADY_I,
   input  wire logic                          OVF_EVENT_I,
   input  wire logic [tmv_pkg::NUM_CH-1:0]    CH_EVENT_I,
   input  wire logic                          GLOBAL_IRQ_ENABLE_I,
   input  wire logic                          CH0_IRQ_ACK_I,
   output logic                               CH0_IRQ_O,
   output logic                               SHARED_IRQ_O,
   output logic                               IRQ_O
);
   import tmv_pkg::*;

   // ***************************************************************
   // declarations
   // ***************************************************************
   tmv_wr_state_t               wr_state_q;
   tmv_rd_state_t               rd_state_q;
   logic                        aw_got_q;
   logic                        w_got_q;
   logic [ADDR_W-1:0]           wr_addr_q;
   logic [REG_W-1:0]            wr_data_q;
   logic [STRB_W-1:0]           wr_strb_q;
   logic [REG_W-1:0]            ctl_q [NUM_SLOT];
   logic [REG_W-1:0]            val_q [NUM_SLOT];
   logic [REG_W-1:0]            ctl_view [NUM_SLOT];
   logic [REG_W-1:0]            exp_q;
   logic [ST_W-1:0]             st_q;
   logic [ST_W-1:0]             mask_q;
   logic [NUM_SRC-1:0]          flag;
   logic [NUM_SRC-1:0]          ie;
   logic [SHR_W-1:0]            pend;
   logic [SHR_W-1:0]            sel;
   logic [SHR_W-1:0]            vec_clr;
   logic [VEC_W-1:0]            vec_code;
   logic [IDX_W-1:0]            wr_idx;
   logic [IDX_W-1:0]            rd_idx;
   logic                        wr_commit;
   logic                        rd_accept;
   logic                        wr_ok;
   logic                        rd_ok;
   logic [REG_W-1:0]            rd_word;
   logic                        vec_access;
   logic [ST_W-1:0]             st_event;

   // ***************************************************************
   // address decode helpers
   // ***************************************************************
   function automatic logic in_range(input logic [IDX_W-1:0] idx,
                                     input logic [IDX_W-1:0] lo,
                                     input logic [IDX_W-1:0] hi);
      in_range = (idx >= lo) && (idx <= hi) && !idx[0];
   endfunction : in_range

   function automatic logic [SLOT_W-1:0] slot_of(input logic [IDX_W-1:0] idx,
                                                input logic [IDX_W-1:0] base);
      logic [IDX_W-1:0] d;
      d = IDX_W'(idx - base);
      slot_of = SLOT_W'(d >> STEP_SH);
   endfunction : slot_of

   function automatic logic mapped(input logic [IDX_W-1:0] idx);
      mapped = in_range(idx, IDX_TIMER_CONTROL, IDX_CHANNEL6_CONTROL) ||
               in_range(idx, IDX_COUNTER_VALUE, IDX_CHANNEL6_VALUE) ||
               (idx == IDX_CLOCK_EXPANSION) || (idx == IDX_IRQ_VECTOR) ||
               (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK);
   endfunction : mapped

   // byte lanes 0 and 1 carry the 16-bit registers; upper lanes are ignored
   function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                              input logic [REG_W-1:0] data,
                                              input logic [STRB_W-1:0] strb);
      logic [REG_W-1:0] r;
      r = old;
      for (int b = 0; b < REG_W / BYTE_W; b++)
      begin
         if (strb[b])
            r[b*BYTE_W +: BYTE_W] = data[b*BYTE_W +: BYTE_W];
      end
      merge = r;
   endfunction : merge

   assign wr_idx    = wr_addr_q[ADDR_W-1:BYTE_SH];
   assign rd_idx    = ARADDR_I[ADDR_W-1:BYTE_SH];
   assign wr_ok     = mapped(wr_idx);
   assign rd_ok     = mapped(rd_idx);
   assign wr_commit = CE_I && (wr_state_q == WR_COLLECT) && aw_got_q && w_got_q;
   assign rd_accept = CE_I && (rd_state_q == RD_IDLE) && ARVALID_I && ARREADY_O;

   // ***************************************************************
   // flag cells and ranking
   // ***************************************************************
   // source 0 is channel 0, 1..6 channels 1..6, 7 overflow
   // control slot 0 is the timer control, slot k is channel k-1
   generate
      for (genvar s = 0; s < NUM_SRC; s++)
      begin : g_src
         localparam int SLOT = (s == NUM_SRC - 1) ? 0 : s + 1;
         logic ev;
         logic clr;
         logic sw_wr;
         assign ev    = (s == NUM_SRC - 1) ? OVF_EVENT_I : CH_EVENT_I[s % NUM_CH];
         assign clr   = (s == 0) ? CH0_IRQ_ACK_I : vec_clr[(s == 0) ? 0 : s - 1];
         assign sw_wr = wr_commit && wr_strb_q[0] &&
                        in_range(wr_idx, IDX_TIMER_CONTROL, IDX_CHANNEL6_CONTROL) &&
                        (slot_of(wr_idx, IDX_TIMER_CONTROL) == SLOT_W'(SLOT));
         assign ie[s] = (s == NUM_SRC - 1) ? ctl_q[0][OVF_IE_BIT] : ctl_q[SLOT][CH_IE_BIT];
         assign ctl_view[SLOT] = (ctl_q[SLOT] & ~FLAG_MASK) |
                                 (REG_W'(flag[s]) << FLAG_BIT);
         tmv_evflag u_flag
         (
            .clk_i    (CLOCK_I),
            .rst_n_i  (RESETN_I),
            .ce_i     (CE_I),
            .set_i    (ev),
            .wr_i     (sw_wr),
            .wr_val_i (wr_data_q[FLAG_BIT]),
            .clr_i    (clr),
            .flag_o   (flag[s])
         );
      end
   endgenerate

   // channel 0 is left out of the shared ranking
   assign pend = flag[NUM_SRC-1:1] & ie[NUM_SRC-1:1];

   tmv_prio u_prio
   (
      .pend_i (pend),
      .code_o (vec_code),
      .sel_o  (sel)
   );

   // a read and a write hitting the vector together clear only one source
   assign vec_access = (wr_commit && (wr_idx == IDX_IRQ_VECTOR)) ||
                       (rd_accept && (rd_idx == IDX_IRQ_VECTOR));
   assign vec_clr    = vec_access ? sel : '0;

   // ***************************************************************
   // write channel
   // ***************************************************************
   always_ff @(posedge CLOCK_I)
   begin
      if (!RESETN_I)
      begin
         wr_state_q <= WR_COLLECT;
         aw_got_q   <= 1'b0;
         w_got_q    <= 1'b0;
         AWREADY_O  <= 1'b1;
         WREADY_O   <= 1'b1;
         BVALID_O   <= 1'b0;
         BRESP_O    <= RESP_OKAY;
         wr_addr_q  <= '0;
         wr_data_q  <= REG_RESET;
         wr_strb_q  <= '0;
      end
      else if (CE_I)
      begin
         case (wr_state_q)
            WR_COLLECT:
            begin
               if (AWVALID_I && AWREADY_O)
               begin
                  wr_addr_q <= AWADDR_I;
                  aw_got_q  <= 1'b1;
                  AWREADY_O <= 1'b0;
               end
               if (WVALID_I && WREADY_O)
               begin
                  wr_data_q <= WDATA_I[REG_W-1:0];
                  wr_strb_q <= WSTRB_I;
                  w_got_q   <= 1'b1;
                  WREADY_O  <= 1'b0;
               end
               if (wr_commit)
               begin
                  aw_got_q   <= 1'b0;
                  w_got_q    <= 1'b0;
                  BVALID_O   <= 1'b1;
                  BRESP_O    <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                  wr_state_q <= WR_RESP;
               end
            end
            WR_RESP:
            begin
               if (BREADY_I)
               begin
                  BVALID_O   <= 1'b0;
                  AWREADY_O  <= 1'b1;
                  WREADY_O   <= 1'b1;
                  wr_state_q <= WR_COLLECT;
               end
            end
            default:
               wr_state_q <= WR_COLLECT;
         endcase
      end
   end

   // ***************************************************************
   // register storage
   // ***************************************************************
   // the flag bit of each control word lives in its flag cell
   always_ff @(posedge CLOCK_I)
   begin
      if (!RESETN_I)
      begin
         for (int k = 0; k < NUM_SLOT; k++)
            ctl_q[k] <= REG_RESET;
      end
      else if (CE_I && wr_commit &&
               in_range(wr_idx, IDX_TIMER_CONTROL, IDX_CHANNEL6_CONTROL))
      begin
         ctl_q[slot_of(wr_idx, IDX_TIMER_CONTROL)] <=
            merge(ctl_q[slot_of(wr_idx, IDX_TIMER_CONTROL)], wr_data_q, wr_strb_q) &
            ((wr_idx == IDX_TIMER_CONTROL) ? TCTL_WMASK : ~REG_RESET);
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RESETN_I)
      begin
         for (int k = 0; k < NUM_SLOT; k++)
            val_q[k] <= REG_RESET;
      end
      else if (CE_I && wr_commit &&
               in_range(wr_idx, IDX_COUNTER_VALUE, IDX_CHANNEL6_VALUE))
      begin
         val_q[slot_of(wr_idx, IDX_COUNTER_VALUE)] <=
            merge(val_q[slot_of(wr_idx, IDX_COUNTER_VALUE)], wr_data_q, wr_strb_q);
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RESETN_I)
         exp_q <= REG_RESET;
      else if (CE_I && wr_commit && (wr_idx == IDX_CLOCK_EXPANSION))
         exp_q <= merge(exp_q, wr_data_q, wr_strb_q);
   end

   // ***************************************************************
   // read channel
   // ***************************************************************
   always_comb
   begin
      rd_word = REG_RESET;
      if (in_range(rd_idx, IDX_TIMER_CONTROL, IDX_CHANNEL6_CONTROL))
         rd_word = ctl_view[slot_of(rd_idx, IDX_TIMER_CONTROL)];
      else if (in_range(rd_idx, IDX_COUNTER_VALUE, IDX_CHANNEL6_VALUE))
         rd_word = val_q[slot_of(rd_idx, IDX_COUNTER_VALUE)];
      else if (rd_idx == IDX_CLOCK_EXPANSION)
         rd_word = exp_q;
      else if (rd_idx == IDX_IRQ_VECTOR)
         rd_word = REG_W'(vec_code);
      else if (rd_idx == IDX_IRQ_STATUS)
         rd_word = REG_W'(st_q);
      else if (rd_idx == IDX_IRQ_MASK)
         rd_word = REG_W'(mask_q);
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RESETN_I)
      begin
         rd_state_q <= RD_IDLE;
         ARREADY_O  <= 1'b1;
         RVALID_O   <= 1'b0;
         RDATA_O    <= '0;
         RRESP_O    <= RESP_OKAY;
      end
      else if (CE_I)
      begin
         case (rd_state_q)
            RD_IDLE:
            begin
               if (rd_accept)
               begin
                  RDATA_O    <= DATA_W'(rd_word);
                  RRESP_O    <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                  RVALID_O   <= 1'b1;
                  ARREADY_O  <= 1'b0;
                  rd_state_q <= RD_DATA;
               end
            end
            RD_DATA:
            begin
               if (RREADY_I)
               begin
                  RVALID_O   <= 1'b0;
                  ARREADY_O  <= 1'b1;
                  rd_state_q <= RD_IDLE;
               end
            end
            default:
               rd_state_q <= RD_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // block status, mask and interrupt lines
   // ***************************************************************
   assign st_event[ST_SERVICED] = vec_access && (|pend);
   assign st_event[ST_UNMAPPED] = (wr_commit && !wr_ok) || (rd_accept && !rd_ok);

   // a fresh event beats a write-one-to-clear in the same cycle
   always_ff @(posedge CLOCK_I)
   begin
      if (!RESETN_I)
         st_q <= '0;
      else if (CE_I)
      begin
         if (wr_commit && (wr_idx == IDX_IRQ_STATUS) && wr_strb_q[0])
            st_q <= (st_q & ~wr_data_q[ST_W-1:0]) | st_event;
         else
            st_q <= st_q | st_event;
      end
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RESETN_I)
         mask_q <= '0;
      else if (CE_I && wr_commit && (wr_idx == IDX_IRQ_MASK) && wr_strb_q[0])
         mask_q <= wr_data_q[ST_W-1:0];
   end

   // requests are registered, so they follow the flags by one cycle
   always_ff @(posedge CLOCK_I)
   begin
      if (!RESETN_I)
      begin
         SHARED_IRQ_O <= 1'b0;
         CH0_IRQ_O    <= 1'b0;
         IRQ_O        <= 1'b0;
      end
      else if (CE_I)
      begin
         SHARED_IRQ_O <= (|pend) && GLOBAL_IRQ_ENABLE_I;
         CH0_IRQ_O    <= flag[0] && ie[0] && GLOBAL_IRQ_ENABLE_I;
         IRQ_O        <= |(st_q & mask_q);
      end
   end

endmodule : tmv_top

//--- tmv_core_model.sv
// behavioural processor core: global enable and channel 0 service
module tmv_core_model
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic irq_on_i,
   input  wire logic slow_i,
   input  wire logic ch0_irq_i,
   output logic      ien_o,
   output logic      ack_o
);
   // ***************
   // service sequencer
   // ***************
   // enable drops on handler entry; idle tail lets the request fall before re-arming
   logic [2:0] cnt_q;
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 3'h0;
         ien_o <= 1'b0;
         ack_o <= 1'b0;
      end
      else
      begin
         if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
         else if (ch0_irq_i && ien_o)
            cnt_q <= slow_i ? 3'h7 : 3'h4;
         ack_o <= (cnt_q == 3'h3);
         ien_o <= irq_on_i && (cnt_q == 3'h0) && !(ch0_irq_i && ien_o);
      end
   end
endmodule : tmv_core_model

//--- tmv_top_asserts.sv
// port-level assertions for the timer interrupt vector block
module tmv_asserts
(
   input wire logic        CLOCK_I,
   input wire logic        RESETN_I,
   input wire logic        CE_I,
   input wire logic        AWVALID_I,
   input wire logic        AWREADY_O,
   input wire logic        WVALID_I,
   input wire logic        WREADY_O,
   input wire logic [1:0]  BRESP_O,
   input wire logic        BVALID_O,
   input wire logic        BREADY_I,
   input wire logic [7:0]  ARADDR_I,
   input wire logic        ARVALID_I,
   input wire logic        ARREADY_O,
   input wire logic [31:0] RDATA_O,
   input wire logic [1:0]  RRESP_O,
   input wire logic        RVALID_O,
   input wire logic        RREADY_I,
   input wire logic [6:0]  CH_EVENT_I,
   input wire logic        GLOBAL_IRQ_ENABLE_I,
   input wire logic        CH0_IRQ_ACK_I,
   input wire logic        CH0_IRQ_O,
   input wire logic        SHARED_IRQ_O
);
   import tmv_pkg::*;
   // ***************
   // helper and checks
   // ***************
   logic vec_rd_q;
   always_ff @(posedge CLOCK_I)
   begin
      if (!RESETN_I)
         vec_rd_q <= 1'b0;
      else if (ARVALID_I && ARREADY_O && CE_I)
         vec_rd_q <= (ARADDR_I == 8'hb8);
   end
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   chk_ien_shared: assert property ($past(CE_I) && !$past(GLOBAL_IRQ_ENABLE_I) |-> !SHARED_IRQ_O)
      else $error("shared request without global enable");
   chk_ien_ch0: assert property ($past(CE_I) && !$past(GLOBAL_IRQ_ENABLE_I) |-> !CH0_IRQ_O)
      else $error("channel 0 request without global enable");
   chk_ch0_ack_drop: assert property (CE_I && CH0_IRQ_ACK_I && !CH_EVENT_I[0] ##1 CE_I && !CH_EVENT_I[0] |=> !CH0_IRQ_O)
      else $error("channel 0 request stays after service");
   chk_vec_even: assert property (RVALID_O && vec_rd_q |-> RDATA_O[31:4] == '0 && !RDATA_O[0] && RRESP_O == RESP_OKAY)
      else $error("vector code not even or out of range");
   chk_rd_accept: assert property (ARVALID_I && ARREADY_O && CE_I |=> RVALID_O && !ARREADY_O)
      else $error("read answer missing");
   chk_r_hold: assert property (RVALID_O && !(RREADY_I && CE_I) |=> RVALID_O && $stable(RDATA_O))
      else $error("read data dropped before taken");
   chk_b_hold: assert property (BVALID_O && !(BREADY_I && CE_I) |=> BVALID_O && $stable(BRESP_O))
      else $error("write response dropped before taken");
   chk_wr_resp_time: assert property (CE_I && AWVALID_I && AWREADY_O && WVALID_I && WREADY_O ##1 CE_I
      |-> !BVALID_O ##1 BVALID_O)
      else $error("write response timing wrong");
   chk_unmapped_rd: assert property (ARVALID_I && ARREADY_O && CE_I && ARADDR_I == 8'h04
      |=> RRESP_O == RESP_SLVERR && RDATA_O == '0)
      else $error("unmapped read not refused");
   cov_vec_read: cover property (RVALID_O && vec_rd_q && RDATA_O != '0);
   cov_ch0_ack: cover property (CH0_IRQ_ACK_I);
   cov_wr_done: cover property (BVALID_O && BREADY_I);
endmodule : tmv_asserts

bind tmv_top tmv_asserts i_chk (.*);

//--- tmv_tb.sv
// self-checking bench for the timer interrupt vector block
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tmv_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, ovf_ev = 1'b0, irq_on = 1'b1, slow = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'hf;
   logic [6:0]  ch_ev = 7'h00;
   logic        awready, wready, bvalid, arready, rvalid, ien, ack, ch0_irq, shared_irq, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          fail_count = 0, n_checks = 0;
   always #12.5 clk = ~clk;
   tmv_top i_dut
   (
      .CLOCK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
      .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
      .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
      .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
      .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .OVF_EVENT_I(ovf_ev),
      .CH_EVENT_I(ch_ev), .GLOBAL_IRQ_ENABLE_I(ien), .CH0_IRQ_ACK_I(ack),
      .CH0_IRQ_O(ch0_irq), .SHARED_IRQ_O(shared_irq), .IRQ_O(irq)
   );
   tmv_core_model i_core
   (
      .clk_i(clk), .rst_n_i(rst_n), .irq_on_i(irq_on), .slow_i(slow), .ch0_irq_i(ch0_irq),
      .ien_o(ien), .ack_o(ack)
   );
   // ***************
   // bus and event tasks
   // ***************
   // each channel is released at the edge where its ready is seen, never earlier
   task automatic wro(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (!bvalid);
      bready <= 1'b0;
      `CHK(bresp, er)
   endtask : wro
   task automatic chk_rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end
      while (!rvalid);
      rready <= 1'b0;
      `CHK(rdata, {16'h0000, e})
      `CHK(rresp, er)
   endtask : chk_rd
   task automatic ev(input logic o, input logic [6:0] c);
      @(posedge clk);
      ovf_ev <= o;
      ch_ev <= c;
      @(posedge clk);
      ovf_ev <= 1'b0;
      ch_ev <= 7'h00;
      repeat (2) @(posedge clk);
   endtask : ev
   // ***************
   // scenarios
   // ***************
   task automatic t_reset;
      for (logic [7:0] a = 8'h00; a <= 8'h80; a += 8'h08)
      begin
         chk_rd(a, 16'h0000, RESP_OKAY);
      end
      chk_rd(8'hb8, 16'h0000, RESP_OKAY);
   endtask : t_reset
   task automatic t_ctrl;
      wro(8'h00, 16'hffff, RESP_OKAY);
      repeat (2) @(posedge clk);
      `CHK(shared_irq, 1'b1)
      chk_rd(8'h00, 16'h7bff, RESP_OKAY);
      chk_rd(8'hb8, 16'h000e, RESP_OKAY);
      chk_rd(8'h00, 16'h7bfe, RESP_OKAY);
      wro(8'h00, 16'h0002, RESP_OKAY);
   endtask : t_ctrl
   task automatic t_map;
      for (logic [7:0] a = 8'h40; a <= 8'h80; a += 8'h08)
      begin
         wro(a, {8'h5a, a}, RESP_OKAY);
      end
      for (logic [7:0] a = 8'h40; a <= 8'h80; a += 8'h08)
      begin
         chk_rd(a, {8'h5a, a}, RESP_OKAY);
      end
   endtask : t_map
   task automatic t_unmapped;
      chk_rd(8'h04, 16'h0000, RESP_SLVERR);
      wro(8'h0c, 16'h1234, RESP_SLVERR);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      wro(8'hc8, 16'h0002, RESP_OKAY);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      wro(8'hc0, 16'h0003, RESP_OKAY);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
   endtask : t_unmapped
   task automatic t_prio;
      for (logic [7:0] a = 8'h08; a <= 8'h38; a += 8'h08)
      begin
         wro(a, 16'h0010, RESP_OKAY);
      end
      ev(1'b1, 7'h7f);
      repeat (10) @(posedge clk);
      `CHK(ch0_irq, 1'b0)
      `CHK(shared_irq, 1'b1)
      chk_rd(8'h08, 16'h0010, RESP_OKAY);
      for (int k = 1; k <= 7; k++)
      begin
         chk_rd(8'hb8, 16'(2 * k), RESP_OKAY);
         repeat (2) @(posedge clk);
         `CHK(shared_irq, k < 7)
      end
      chk_rd(8'hb8, 16'h0000, RESP_OKAY);
   endtask : t_prio
   task automatic t_disabled;
      wro(8'h10, 16'h0000, RESP_OKAY);
      ev(1'b0, 7'h2a);
      wro(8'hb8, 16'h0000, RESP_OKAY);
      chk_rd(8'hb8, 16'h000a, RESP_OKAY);
      chk_rd(8'h10, 16'h0001, RESP_OKAY);
      chk_rd(8'hb8, 16'h0000, RESP_OKAY);
      wro(8'h10, 16'h0000, RESP_OKAY);
   endtask : t_disabled
   task automatic t_ien;
      irq_on <= 1'b0;
      wro(8'h18, 16'h0011, RESP_OKAY);
      repeat (3) @(posedge clk);
      `CHK(shared_irq, 1'b0)
      irq_on <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(shared_irq, 1'b1)
      chk_rd(8'hb8, 16'h0004, RESP_OKAY);
      slow <= 1'b1;
      ev(1'b0, 7'h01);
      `CHK(ch0_irq, 1'b1)
      `CHK(shared_irq, 1'b0)
      repeat (15) @(posedge clk);
      `CHK(ch0_irq, 1'b0)
      chk_rd(8'h08, 16'h0010, RESP_OKAY);
      ce <= 1'b0;
      ev(1'b1, 7'h00);
      ce <= 1'b1;
      chk_rd(8'hb8, 16'h0000, RESP_OKAY);
   endtask : t_ien
   task automatic print_verdict;
      if (fail_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_ctrl();
      t_map();
      t_unmapped();
      t_prio();
      t_disabled();
      t_ien();
      print_verdict();
   end
   initial
   begin
      #500000;
      fail_count++;
      print_verdict();
   end
endmodule : tb
